// file: sica_pkg.sv
`default_nettype none
package sica_pkg;
  // ----------------------------------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [11:0] OFF_PORT1_FC    = 12'h1a0;
  localparam logic [11:0] OFF_PORT2_FC    = 12'h1a4;
  localparam logic [11:0] OFF_PORT0_FC    = 12'h1a8;
  localparam logic [11:0] OFF_IND_DATA    = 12'h1ac;
  localparam logic [11:0] OFF_IND_CMD     = 12'h1b0;
  localparam logic [11:0] OFF_PAUSE_HI    = 12'h1f0;
  localparam logic [11:0] OFF_PAUSE_LO    = 12'h1f4;
  localparam logic [11:0] OFF_WIN_FIRST   = 12'h200;
  localparam logic [11:0] OFF_WIN_LAST    = 12'h2f8;
  // ----------------------------------------------------------------
  // command register fields
  // ----------------------------------------------------------------
  localparam int CMD_PENDING_BIT = 31;
  localparam int CMD_RNW_BIT     = 30;
  localparam int CMD_UP_BIT      = 29;
  localparam int CMD_DOWN_BIT    = 28;
  localparam int CMD_LANE_LSB    = 16;
  localparam int CMD_ADDR_LSB    = 0;
  localparam logic [3:0]  LANES_ALL     = 4'hf;
  localparam logic [31:0] FC_WR_MASK    = 32'h0000_0047;
  localparam logic [31:0] PAUSE_HI_MASK = 32'h0000_ffff;
  localparam logic [31:0] RESET_WORD    = 32'h0000_0000;
  // window map base into internal space, one internal register per word
  localparam logic [15:0] WIN_MAP_BASE  = 16'h0000;
  // ----------------------------------------------------------------
  // sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SICA_IDLE  = 2'b00,
    SICA_ISSUE = 2'b01,
    SICA_WAIT  = 2'b10
  } sica_state_t;
endpackage : sica_pkg
`default_nettype wire

// file: sica_win_map.sv
`default_nettype none
// ------------------------------------------------------------------
// direct window to internal address map
// ------------------------------------------------------------------
module sica_win_map (
  input  wire logic [11:0] host_addr,
  output logic             in_window,
  output logic [15:0]      mapped_addr
);
  logic [11:0] rel;
  always_comb begin
    rel = host_addr - sica_pkg::OFF_WIN_FIRST;
    in_window = (host_addr >= sica_pkg::OFF_WIN_FIRST) &&
                (host_addr <= sica_pkg::OFF_WIN_LAST);
    // fixed subset: window word n maps to internal register n
    mapped_addr = sica_pkg::WIN_MAP_BASE + {6'h00, rel[11:2]};
  end
endmodule : sica_win_map
`default_nettype wire

// file: sica_int_port.sv
`default_nettype none
// ------------------------------------------------------------------
// internal bus strobe shaper: request held until done, then one-cycle finished
// ------------------------------------------------------------------
module sica_int_port (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic start,
  input  wire logic int_done,
  output logic      int_req,
  output logic      finished
);
  logic req_d, req_q, fin_d, fin_q;
  always_comb begin
    req_d = req_q;
    fin_d = 1'b0;
    if (start) begin
      req_d = 1'b1;
    end else if (req_q && int_done) begin
      req_d = 1'b0;
      fin_d = 1'b1;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      req_q <= 1'b0;
      fin_q <= 1'b0;
    end else begin
      req_q <= req_d;
      fin_q <= fin_d;
    end
  end
  assign int_req  = req_q;
  assign finished = fin_q;
endmodule : sica_int_port
`default_nettype wire

// file: sica_bridge.sv
`default_nettype none
module sica_bridge (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic             pready,
  output logic             pslverr,
  output logic [31:0]      prdata,
  output logic             int_req,
  output logic             int_write,
  output logic [15:0]      int_addr,
  output logic [3:0]       int_lanes,
  output logic [31:0]      int_wdata,
  input  wire logic        int_done,
  input  wire logic [31:0] int_rdata,
  input  wire logic [6:0]  port_fc_status [3],
  output logic [6:0]       port_fc_ctrl [3],
  output logic [47:0]      pause_src_mac
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  sica_pkg::sica_state_t st_d, st_q;
  logic [31:0] data_d, data_q;
  logic        pend_d, pend_q, rnw_d, rnw_q, up_d, up_q, dn_d, dn_q;
  logic [3:0]  lane_d, lane_q;
  logic [15:0] addr_d, addr_q;
  logic [31:0] fc_d [3];
  logic [31:0] fc_q [3];
  logic [31:0] phi_d, phi_q, plo_d, plo_q;
  logic [31:0] rd_d, rd_q;
  logic        rdy_d, rdy_q, err_d, err_q;
  logic        wr_q;
  logic        start, finished, req_w;
  logic        in_window;
  logic [15:0] win_addr;
  logic        setup, wr_acc, rd_acc;

  sica_win_map u_map (
    .host_addr   (paddr),
    .in_window   (in_window),
    .mapped_addr (win_addr)
  );

  sica_int_port u_port (
    .pclk     (pclk),
    .presetn  (presetn),
    .start    (start),
    .int_done (int_done),
    .int_req  (req_w),
    .finished (finished)
  );

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return r;
  endfunction : merge

  function automatic logic [15:0] step(input logic [15:0] a,
                                       input logic u, input logic d);
    logic [15:0] r;
    r = a;
    if (u) begin
      r = a + 16'h0001;
    end else if (d) begin
      r = a - 16'h0001;
    end
    return r;
  endfunction : step

  // ----------------------------------------------------------------
  // apb decode: one wait state, answer in the second access cycle
  // ----------------------------------------------------------------
  always_comb begin
    setup  = psel && penable && !rdy_q;
    wr_acc = setup && pwrite;
    rd_acc = setup && !pwrite;
  end

  // ----------------------------------------------------------------
  // register and sequencer next state
  // ----------------------------------------------------------------
  always_comb begin
    st_d   = st_q;
    data_d = data_q;
    pend_d = pend_q;
    rnw_d  = rnw_q;
    up_d   = up_q;
    dn_d   = dn_q;
    lane_d = lane_q;
    addr_d = addr_q;
    fc_d   = fc_q;
    phi_d  = phi_q;
    plo_d  = plo_q;
    rd_d   = rd_q;
    rdy_d  = setup;
    err_d  = 1'b0;
    start  = 1'b0;
    if (wr_acc) begin
      case (paddr)
        sica_pkg::OFF_PORT1_FC: fc_d[1] = merge(fc_q[1],
                                   pwdata & sica_pkg::FC_WR_MASK, pstrb);
        sica_pkg::OFF_PORT2_FC: fc_d[2] = merge(fc_q[2],
                                   pwdata & sica_pkg::FC_WR_MASK, pstrb);
        sica_pkg::OFF_PORT0_FC: fc_d[0] = merge(fc_q[0],
                                   pwdata & sica_pkg::FC_WR_MASK, pstrb);
        sica_pkg::OFF_PAUSE_HI: phi_d = merge(phi_q,
                                   pwdata & sica_pkg::PAUSE_HI_MASK, pstrb);
        sica_pkg::OFF_PAUSE_LO: plo_d = merge(plo_q, pwdata, pstrb);
        sica_pkg::OFF_IND_DATA: begin
          data_d = merge(data_q, pwdata, pstrb);
          if (!pend_q && !rnw_q && (up_q || dn_q)) begin
            pend_d = 1'b1;
          end
        end
        sica_pkg::OFF_IND_CMD: begin
          if (!pend_q) begin
            pend_d = pwdata[sica_pkg::CMD_PENDING_BIT];
            rnw_d  = pwdata[sica_pkg::CMD_RNW_BIT];
            lane_d = pwdata[sica_pkg::CMD_LANE_LSB +: 4];
            addr_d = pwdata[sica_pkg::CMD_ADDR_LSB +: 16];
          end
          up_d = pwdata[sica_pkg::CMD_UP_BIT];
          dn_d = pwdata[sica_pkg::CMD_DOWN_BIT];
        end
        default: begin
          if (in_window && !pend_q) begin
            data_d = pwdata;
            addr_d = win_addr;
            lane_d = sica_pkg::LANES_ALL;
            rnw_d  = 1'b0;
            pend_d = 1'b1;
          end else if (!in_window) begin
            err_d = 1'b1;
          end
        end
      endcase
    end
    if (rd_acc) begin
      case (paddr)
        sica_pkg::OFF_PORT1_FC: rd_d = {25'h0, port_fc_status[1][6:3],
                                        fc_q[1][2:0]} | (fc_q[1] &
                                        sica_pkg::FC_WR_MASK);
        sica_pkg::OFF_PORT2_FC: rd_d = {25'h0, port_fc_status[2][6:3],
                                        fc_q[2][2:0]} | (fc_q[2] &
                                        sica_pkg::FC_WR_MASK);
        sica_pkg::OFF_PORT0_FC: rd_d = {25'h0, port_fc_status[0][6:3],
                                        fc_q[0][2:0]} | (fc_q[0] &
                                        sica_pkg::FC_WR_MASK);
        sica_pkg::OFF_PAUSE_HI: rd_d = phi_q;
        sica_pkg::OFF_PAUSE_LO: rd_d = plo_q;
        sica_pkg::OFF_IND_DATA: begin
          rd_d = data_q;
          if (!pend_q && rnw_q && (up_q || dn_q)) begin
            addr_d = step(addr_q, up_q, dn_q);
            pend_d = 1'b1;
          end
        end
        sica_pkg::OFF_IND_CMD: rd_d = {pend_q, rnw_q, up_q, dn_q, 8'h00,
                                       lane_q, addr_q};
        default: begin
          rd_d  = sica_pkg::RESET_WORD;
          err_d = !in_window;
        end
      endcase
    end
    case (st_q)
      sica_pkg::SICA_IDLE: begin
        if (pend_q) begin
          st_d = sica_pkg::SICA_ISSUE;
        end
      end
      sica_pkg::SICA_ISSUE: begin
        start = 1'b1;
        st_d  = sica_pkg::SICA_WAIT;
      end
      sica_pkg::SICA_WAIT: begin
        // read data only stands with done, a cycle before finished
        if (req_w && int_done && rnw_q) begin
          data_d = int_rdata;
        end
        if (finished) begin
          if (!rnw_q && (up_q || dn_q)) begin
            addr_d = step(addr_q, up_q, dn_q);
          end
          pend_d = 1'b0;
          st_d   = sica_pkg::SICA_IDLE;
        end
      end
      default: st_d = sica_pkg::SICA_IDLE;
    endcase
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q   <= sica_pkg::SICA_IDLE;
      data_q <= sica_pkg::RESET_WORD;
      pend_q <= 1'b0;
      rnw_q  <= 1'b0;
      up_q   <= 1'b0;
      dn_q   <= 1'b0;
      lane_q <= 4'h0;
      addr_q <= 16'h0000;
      for (int i = 0; i < 3; i++) begin
        fc_q[i] <= sica_pkg::RESET_WORD;
      end
      phi_q  <= sica_pkg::RESET_WORD;
      plo_q  <= sica_pkg::RESET_WORD;
      rd_q   <= sica_pkg::RESET_WORD;
      rdy_q  <= 1'b0;
      err_q  <= 1'b0;
      wr_q   <= 1'b1;
    end else begin
      st_q   <= st_d;
      data_q <= data_d;
      pend_q <= pend_d;
      rnw_q  <= rnw_d;
      up_q   <= up_d;
      dn_q   <= dn_d;
      lane_q <= lane_d;
      addr_q <= addr_d;
      fc_q   <= fc_d;
      phi_q  <= phi_d;
      plo_q  <= plo_d;
      rd_q   <= rd_d;
      rdy_q  <= rdy_d;
      err_q  <= err_d;
      wr_q   <= !rnw_d;
    end
  end

  // outputs: data, address and lanes are held registers
  assign pready        = rdy_q;
  assign pslverr       = err_q;
  assign prdata        = rd_q;
  assign int_req       = req_w;
  assign int_write     = wr_q;
  assign int_addr      = addr_q;
  assign int_lanes     = lane_q;
  assign int_wdata     = data_q;
  assign pause_src_mac = {phi_q[15:0], plo_q};
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      port_fc_ctrl[i] = fc_q[i][6:0];
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  a_pend_clears_done: assert property (@(posedge pclk) disable iff (!presetn)
    (st_q == sica_pkg::SICA_WAIT && finished) |=> !pend_q)
    else $error("pending did not clear on completion");
  a_cmd_starts_acc: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_acc && paddr == sica_pkg::OFF_IND_CMD && !pend_q &&
     pwdata[sica_pkg::CMD_PENDING_BIT]) |=> pend_q ##2 int_req)
    else $error("command did not start access");
  a_win_loads_cmd: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_acc && in_window && !pend_q) |=>
      (pend_q && !rnw_q && lane_q == 4'hf && addr_q == $past(win_addr)))
    else $error("window write did not load command");
  a_read_data_land: assert property (@(posedge pclk) disable iff (!presetn)
    (st_q == sica_pkg::SICA_WAIT && req_w && int_done && rnw_q) |=>
      data_q == $past(int_rdata))
    else $error("read data not captured");
  a_seq_wr_step: assert property (@(posedge pclk) disable iff (!presetn)
    (st_q == sica_pkg::SICA_WAIT && finished && !rnw_q && up_q) |=>
      addr_q == $past(addr_q) + 16'h0001)
    else $error("sequential write address did not step");
  a_seq_rd_restart: assert property (@(posedge pclk) disable iff (!presetn)
    (rd_acc && paddr == sica_pkg::OFF_IND_DATA && !pend_q && rnw_q &&
     dn_q) |=> (pend_q && addr_q == $past(addr_q) - 16'h0001))
    else $error("sequential read did not restart");
  a_seq_wr_start: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_acc && paddr == sica_pkg::OFF_IND_DATA && !pend_q && !rnw_q &&
     (up_q || dn_q)) |=> pend_q)
    else $error("data write did not start sequential write");
  a_apb_one_wait: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && !penable) ##1 (psel && penable) |=> pready)
    else $error("apb answer not after one wait");
  a_req_until_done: assert property (@(posedge pclk) disable iff (!presetn)
    (int_req && !int_done) |=> int_req)
    else $error("internal request dropped early");
  a_window_range: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_acc && paddr == 12'h2fc) |=> !pend_q || $past(pend_q))
    else $error("write past window started access");
  c_single_write: cover property (@(posedge pclk) disable iff (!presetn)
    pend_q && !rnw_q ##[1:20] !pend_q);
  c_single_read: cover property (@(posedge pclk) disable iff (!presetn)
    pend_q && rnw_q ##[1:20] !pend_q);
  c_window_write: cover property (@(posedge pclk) disable iff (!presetn)
    wr_acc && in_window);
endmodule : sica_bridge
`default_nettype wire

// file: sica_int_model.sv
`default_nettype none
// ----------------------------------------------
// internal register space, prompt or slow answer
// ----------------------------------------------
module sica_int_model (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        int_req,
  input  wire logic        int_write,
  input  wire logic [15:0] int_addr,
  input  wire logic [3:0]  int_lanes,
  input  wire logic [31:0] int_wdata,
  input  wire logic [3:0]  lat,
  output logic             int_done,
  output logic [31:0]      int_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] mem [256];
  logic [31:0] last_q;
  logic [3:0]  cnt_q;
  initial begin
    for (int i = 0; i < 256; i++) begin
      mem[i] = 32'hc0de_0000 | i;
    end
    last_q = 32'h0;
  end
  // data only valid with done; otherwise a pattern that flips
  assign int_rdata = int_done ? last_q : ~last_q;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q    <= 4'h0;
      int_done <= 1'b0;
    end else begin
      int_done <= 1'b0;
      if (!int_req || int_done) begin
        cnt_q <= 4'h0;
      end else if (cnt_q < lat) begin
        cnt_q <= cnt_q + 4'h1;
      end else begin
        int_done <= 1'b1;
        if (int_write) begin
          for (int b = 0; b < 4; b++) begin
            if (int_lanes[b]) begin
              mem[int_addr[7:0]][8*b+:8] <= int_wdata[8*b+:8];
            end
          end
        end else begin
          last_q <= mem[int_addr[7:0]];
        end
      end
    end
  end
endmodule : sica_int_model
`default_nettype wire

// file: sica_bridge_tb.sv
`default_nettype none
module sica_bridge_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk, presetn, psel, penable, pwrite, e;
  logic        pready, pslverr, int_req, int_write, int_done;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, int_wdata, int_rdata, v;
  logic [3:0]  pstrb, int_lanes, lat;
  logic [15:0] int_addr;
  logic [6:0]  fc_st [3];
  logic [6:0]  fc_ctrl [3];
  logic [47:0] mac;
  int          failures, comparisons;
  sica_bridge sica_bridge_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .pready(pready), .pslverr(pslverr), .prdata(prdata),
    .int_req(int_req), .int_write(int_write), .int_addr(int_addr),
    .int_lanes(int_lanes), .int_wdata(int_wdata), .int_done(int_done),
    .int_rdata(int_rdata), .port_fc_status(fc_st), .port_fc_ctrl(fc_ctrl),
    .pause_src_mac(mac));
  sica_int_model sica_int_model_i (.pclk(pclk), .presetn(presetn),
    .int_req(int_req), .int_write(int_write), .int_addr(int_addr),
    .int_lanes(int_lanes), .int_wdata(int_wdata), .lat(lat),
    .int_done(int_done), .int_rdata(int_rdata));
  // ----------------------------------------------
  // shared tasks
  // ----------------------------------------------
  task automatic results;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : results
  task automatic chk(input string nm, input logic [47:0] ex,
                     input logic [47:0] got);
    comparisons++;
    if (got !== ex) begin
      failures++;
      $display("mismatch %s expected %h seen %h", nm, ex, got);
    end
  endtask : chk
  // one apb transfer; pready, prdata and pslverr taken at one rising edge
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, input logic [3:0] s);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    pstrb   <= s;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 40);
    if (n >= 40) begin
      failures++;
      results();
    end
    v = prdata;
    e = pslverr;
    @(posedge pclk);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 4'hf);
  endtask : wr
  task automatic rd(input logic [11:0] a);
    apb(1'b0, a, 32'h0, 4'h0);
  endtask : rd
  // poll pending, bounded; host waits before its next step
  task automatic idle;
    int n;
    n = 0;
    do begin
      rd(sica_pkg::OFF_IND_CMD);
      n++;
    end while (v[31] !== 1'b0 && n < 60);
    if (n >= 60) begin
      failures++;
      results();
    end
  endtask : idle
  function automatic logic [31:0] cmd(input logic p, input logic r,
    input logic u, input logic dn, input logic [15:0] a);
    return {p, r, u, dn, 8'h00, 4'hf, a};
  endfunction : cmd
  // ----------------------------------------------
  // scenarios
  // ----------------------------------------------
  task automatic t_reset;
    rd(sica_pkg::OFF_IND_DATA);
    chk("data reset", 48'h0, v);
    rd(sica_pkg::OFF_IND_CMD);
    chk("cmd reset", 48'h0, v);
    rd(12'h100);
    chk("unmapped err", 48'h1, e);
    rd(12'h2fc);
    chk("past window err", 48'h1, e);
  endtask : t_reset
  task automatic t_single;
    lat <= 4'h6;
    wr(sica_pkg::OFF_IND_DATA, 32'h1122_3344);
    wr(sica_pkg::OFF_IND_CMD, cmd(1, 0, 0, 0, 16'h0010) & 32'hfff5_ffff);
    rd(sica_pkg::OFF_IND_CMD);
    chk("write pending", 48'h8005_0010, v);
    idle();
    chk("write done", 48'h0005_0010, v);
    chk("lane merge", 48'hc022_0044, sica_int_model_i.mem[16]);
    lat <= 4'h0;
    wr(sica_pkg::OFF_IND_CMD, cmd(1, 1, 0, 0, 16'h0010));
    idle();
    rd(sica_pkg::OFF_IND_DATA);
    chk("single read", 48'hc022_0044, v);
  endtask : t_single
  task automatic t_seqw;
    logic [15:0] b;
    for (int m = 0; m < 2; m++) begin
      b = m ? 16'h0048 : 16'h0030;
      wr(sica_pkg::OFF_IND_CMD, cmd(0, 0, m == 0, m == 1, b));
      for (int k = 0; k < 3; k++) begin
        wr(sica_pkg::OFF_IND_DATA, 32'h5a00_0000 + 16 * m + k);
        idle();
      end
      for (int k = 0; k < 3; k++) begin
        chk("seq write", 32'h5a00_0000 + 16 * m + k,
            sica_int_model_i.mem[m ? b - k : b + k]);
      end
      chk("seq addr", m ? b - 3 : b + 3, v[15:0]);
    end
  endtask : t_seqw
  task automatic t_seqr;
    lat <= 4'h6;
    wr(sica_pkg::OFF_IND_CMD, cmd(1, 1, 0, 1, 16'h0032));
    idle();
    rd(sica_pkg::OFF_IND_DATA);
    chk("seq read 0", 48'h5a00_0002, v);
    rd(sica_pkg::OFF_IND_CMD);
    chk("auto reread", 48'hd00f_0031, v);
    idle();
    wr(sica_pkg::OFF_IND_CMD, cmd(0, 1, 0, 0, 16'h0031));
    rd(sica_pkg::OFF_IND_DATA);
    chk("seq read 1", 48'h5a00_0001, v);
    rd(sica_pkg::OFF_IND_CMD);
    chk("no extra read", 48'h400f_0031, v);
  endtask : t_seqr
  task automatic t_win;
    apb(1'b1, 12'h208, 32'h9988_7766, 4'h1);
    rd(sica_pkg::OFF_IND_CMD);
    chk("window cmd", cmd(1, 0, 0, 0, 16'h0002), v);
    idle();
    chk("window word", 48'h9988_7766, sica_int_model_i.mem[2]);
    lat <= 4'h0;
    wr(sica_pkg::OFF_WIN_LAST, 32'h0bad_cafe);
    idle();
    chk("window last", 48'h0bad_cafe, sica_int_model_i.mem[62]);
    wr(12'h2fc, 32'h0bad_cafe);
    chk("window end err", 48'h1, e);
    rd(sica_pkg::OFF_IND_CMD);
    chk("window end idle", 48'h0, v[31]);
  endtask : t_win
  task automatic t_regs;
    logic [11:0] o;
    wr(sica_pkg::OFF_PAUSE_HI, 32'hffff_abcd);
    wr(sica_pkg::OFF_PAUSE_LO, 32'h1234_5678);
    chk("pause mac", 48'habcd_1234_5678, mac);
    rd(sica_pkg::OFF_PAUSE_HI);
    chk("pause high", 48'h0000_abcd, v);
    // write all three first so a shared register shows up
    for (int p = 0; p < 3; p++) begin
      o = 12'h1a0 + 4 * ((p + 2) % 3);
      wr(o, 32'hffff_ff80 | (32'h1 << p));
    end
    for (int p = 0; p < 3; p++) begin
      o = 12'h1a0 + 4 * ((p + 2) % 3);
      rd(o);
      chk("fc read", (48'h1 << p) | fc_st[p], v);
      chk("fc ctrl", 48'h1 << p, fc_ctrl[p]);
    end
  endtask : t_regs
  // ----------------------------------------------
  // clock, reset, sequence
  // ----------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  initial begin
    failures = 0;
    comparisons = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h0;
    pwdata = 32'h0;
    pstrb = 4'h0;
    lat = 4'h0;
    fc_st = '{7'h08, 7'h10, 7'h20};
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_single();
    t_seqw();
    t_seqr();
    t_win();
    t_regs();
    results();
  end
endmodule : sica_bridge_tb
`default_nettype wire
